// ---- rtl/gpr_pkg.sv ----
// Purpose: constants and carriers for the poll response logic of one bus port
// Assumes: single 10 MHz clock, APB register access, bus lines as plain levels
// Notes: bus lines are active-high inside; open-collector data lines use enables
//
// Overview of operation
// R1: dma status line 0 follows port A service request line, active low.
// R2: dma status line 2 follows port A remote enable or port B srq by switch.
// R3: software polls serially: become controller, address, Listen, then Go To Standby.
// R4: software should wait for pending clear before writing new request status byte.
// R5: writing status byte with request-service sets pending until reporting poll ends.
// R6: srq asserts only after any serial poll in progress finishes.
// R7: addressed talker in poll releases srq on atn release, drives status with dio7.
// R8: atn asserted ending poll clears rqs, request-service and pending together.
// R9: with aux mode b bit one set, eoi accompanies the status byte.
// R10: execute parallel poll sends idy once controller is in waiting or active state; the logic sends it only with ctl_wait_i set.
// R11: parallel poll captures data lines, clears rpp, sets command-out ready.
// R12: captured response stays until a command is sent or controller inactive.
// R13: each participant drives exactly one data line, all others passive.
// R14: response sense follows configuration and individual status; sixteen responses.
// R15: data lines are open collector; true overrides false.
// R16: controller configures remotely with UNL, listen address, PPC then PPE.
// R17: controller disables responses with PPD using the same sequence.
// R18: remote configuration commands are decoded by the device without software.
// R19: software writes unconfigure, sense and line select bits for local configuration.
// R20: with status select zero, set and clear parallel poll commands drive status.
// R21: with status select one, status is srq state with srq asserted.
// R22: parallel poll drive released once idy is no longer true.
package gpr_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_SERIAL_POLL_MODE_REG  = 8'h00;
	localparam logic [7:0] ADDR_SERIAL_POLL_STATUS_REG  = 8'h04;
	localparam logic [7:0] ADDR_AUXB  = 8'h08;
	localparam logic [7:0] ADDR_PPCFG = 8'h0C;
	localparam logic [7:0] ADDR_AUXC  = 8'h10;
	localparam logic [7:0] ADDR_COMMAND_PASS_THROUGH_REG  = 8'h14;
	localparam logic [7:0] ADDR_STAT  = 8'h18;
	// field positions
	localparam int BIT_RSV    = 6;
	localparam int BIT_SERVICE_REQUEST_PENDING   = 6;
	localparam int BIT_EOI    = 1;
	localparam int BIT_ISS    = 2;
	localparam int BIT_SENSE  = 3;
	localparam int BIT_UNCFG  = 4;
	localparam int BIT_REMOTE = 5;
	// aux commands (written to ADDR_AUXC)
	localparam logic [7:0] AUX_EPP  = 8'h01;
	localparam logic [7:0] AUX_SPP  = 8'h02;
	localparam logic [7:0] AUX_CPP  = 8'h03;
	// bus commands received under atn (remote configuration), then ppcfg reset value and zero read data
	localparam logic [7:0] CMD_PPC  = 8'h05;
	localparam logic [7:0] CMD_PPU  = 8'h15;
	localparam logic [7:0] PPE_MASK = 8'hF0;
	localparam logic [7:0] PPE_CODE = 8'h60;
	localparam logic [7:0] PPD_CODE = 8'h70;
	localparam logic [7:0] PPCFG_RST = 8'h10;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

	typedef struct packed {
		logic       atn;
		logic       idy;
		logic       srq;
		logic       ren;
		logic       cmd_valid;
		logic [7:0] dio;
	} gpr_bus_in_s;

	typedef struct packed {
		logic       srq;
		logic       eoi;
		logic [7:0] dio;
		logic [7:0] dio_oe;
	} gpr_bus_out_s;

	typedef enum logic [1:0] { SP_IDLE, SP_WAIT, SP_ASSERT, SP_TALK } gpr_sp_e;
endpackage

// ---- rtl/gpr_poll.sv ----
// Purpose: serial and parallel poll handling for one bus port plus dma status lines
// Assumes: bus inputs synchronous to clk_sys_i, active high inside
// Notes: apb slave answers with pready in the access cycle, no wait states
`timescale 1ns/1ns
`default_nettype none
module gpr_poll (
	// clock and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 resetn_i,
	// apb slave
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	output logic      [31:0]          prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	// controller function state of the port
	input  wire logic                 ctl_active_i,
	input  wire logic                 ctl_wait_i,
	input  wire logic                 cmd_sent_i,
	input  wire logic                 talk_addr_i,
	input  wire logic                 listen_addr_i,
	// ieee-488 bus, this port
	input  wire gpr_pkg::gpr_bus_in_s bus_i,
	output gpr_pkg::gpr_bus_out_s     bus_o,
	// dma status lines, active low
	input  wire logic                 srqb_n_i,
	input  wire logic                 sel_ren_i,
	output logic                      dma_status_line0_n_o,
	output logic                      dma_status_line2_n_o
);
	logic [7:0]        stb_r;
	logic              rsv_r;
	logic              service_request_pending_r;
	logic [7:0]        auxb_r;
	logic [7:0]        ppcfg_r;
	logic [7:0]        command_pass_through_reg_r;
	logic              co_r;
	logic              rpp_r;
	logic              ist_r;
	logic              srq_r;
	logic              eoi_r;
	logic [7:0]        dio_r;
	logic [7:0]        oe_r;
	logic [31:0]       rdata_r;
	logic              ready_r;
	logic              serr_r;
	logic              spas_r;
	logic              atn_q_r;
	gpr_pkg::gpr_sp_e  sp_r;
	logic              wr;
	logic              rd;
	logic              ist;
	logic              rsv_wr;
	logic              poll_end;
	logic              mapped;

	assign wr       = psel_i & penable_i & pwrite_i;
	assign rd       = psel_i & penable_i & ~pwrite_i;
	assign rsv_wr   = wr & (paddr_i == gpr_pkg::ADDR_SERIAL_POLL_MODE_REG) & pwdata_i[gpr_pkg::BIT_RSV];
	assign poll_end = spas_r & bus_i.atn & ~atn_q_r;
	assign mapped   = (paddr_i <= gpr_pkg::ADDR_STAT) & (paddr_i[1:0] == 2'b00);
	// individual status source
	assign ist = auxb_r[gpr_pkg::BIT_ISS] ? (sp_r == gpr_pkg::SP_ASSERT) & srq_r // [R21]
		: ist_r; // [R20]

	// dma status lines
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			dma_status_line0_n_o <= 1'b1;
			dma_status_line2_n_o <= 1'b1;
		end else begin
			dma_status_line0_n_o <= ~bus_i.srq; // [R1]
			dma_status_line2_n_o <= sel_ren_i ? ~bus_i.ren : srqb_n_i; // [R2]
		end
	end

	// apb access
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			rdata_r <= gpr_pkg::RD_ZERO;
			ready_r <= 1'b0;
			serr_r  <= 1'b0;
		end else begin
			ready_r <= psel_i & ~penable_i;
			serr_r  <= psel_i & ~penable_i & ~mapped;
			rdata_r <= gpr_pkg::RD_ZERO;
			if (psel_i & ~penable_i & ~pwrite_i) begin
				case (paddr_i)
				gpr_pkg::ADDR_SERIAL_POLL_MODE_REG:  rdata_r <= {24'h0, stb_r[7], rsv_r, stb_r[5:0]};
				gpr_pkg::ADDR_SERIAL_POLL_STATUS_REG:  rdata_r <= {24'h0, stb_r[7], service_request_pending_r, stb_r[5:0]};
				gpr_pkg::ADDR_AUXB:  rdata_r <= {24'h0, auxb_r};
				gpr_pkg::ADDR_PPCFG: rdata_r <= {24'h0, ppcfg_r};
				gpr_pkg::ADDR_COMMAND_PASS_THROUGH_REG:  rdata_r <= {24'h0, command_pass_through_reg_r}; // [R12]
				gpr_pkg::ADDR_STAT:  rdata_r <= {24'h0, 4'h0, ist, rpp_r, spas_r, co_r};
				default:             rdata_r <= gpr_pkg::RD_ZERO;
				endcase
			end
		end
	end
	assign prdata_o  = rdata_r;
	assign pready_o  = ready_r;
	assign pslverr_o = serr_r;

	// configuration registers
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			auxb_r  <= 8'h00;
			ppcfg_r <= gpr_pkg::PPCFG_RST;
		end else begin
			if (wr && paddr_i == gpr_pkg::ADDR_AUXB)
				auxb_r <= pwdata_i[7:0];
			if (wr && paddr_i == gpr_pkg::ADDR_PPCFG) begin
				ppcfg_r <= pwdata_i[7:0]; // [R19]
			end else if (bus_i.cmd_valid && bus_i.atn && ppcfg_r[gpr_pkg::BIT_REMOTE]) begin
				// remote configuration decoded by hardware
				if (bus_i.dio == gpr_pkg::CMD_PPU)
					ppcfg_r[gpr_pkg::BIT_UNCFG] <= 1'b1; // [R18]
				else if (listen_addr_i && (bus_i.dio & gpr_pkg::PPE_MASK) == gpr_pkg::PPE_CODE)
					ppcfg_r[4:0] <= {1'b0, bus_i.dio[3:0]}; // [R18]
				else if (listen_addr_i && (bus_i.dio & gpr_pkg::PPE_MASK) == gpr_pkg::PPD_CODE)
					ppcfg_r[gpr_pkg::BIT_UNCFG] <= 1'b1; // [R18]
			end
		end
	end

	// serial poll response
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			stb_r   <= 8'h00;
			rsv_r   <= 1'b0;
			service_request_pending_r  <= 1'b0;
			spas_r  <= 1'b0;
			atn_q_r <= 1'b1;
			sp_r    <= gpr_pkg::SP_IDLE;
		end else begin
			atn_q_r <= bus_i.atn;
			if (wr && paddr_i == gpr_pkg::ADDR_SERIAL_POLL_MODE_REG) begin
				stb_r <= pwdata_i[7:0];
				rsv_r <= pwdata_i[gpr_pkg::BIT_RSV];
			end
			if (rsv_wr)
				service_request_pending_r <= 1'b1; // [R5]
			case (sp_r)
			gpr_pkg::SP_IDLE: if (rsv_wr) sp_r <= gpr_pkg::SP_WAIT;
			gpr_pkg::SP_WAIT: if (!spas_r) sp_r <= gpr_pkg::SP_ASSERT; // [R6]
			gpr_pkg::SP_ASSERT: begin
				if (talk_addr_i && atn_q_r && !bus_i.atn) begin
					sp_r   <= gpr_pkg::SP_TALK; // [R7]
					spas_r <= 1'b1;
				end
			end
			gpr_pkg::SP_TALK: begin
				if (poll_end) begin
					// a new request written as the poll ends waits its turn for srq
					sp_r   <= rsv_wr ? gpr_pkg::SP_WAIT : gpr_pkg::SP_IDLE; // [R6]
					spas_r <= 1'b0;
					rsv_r  <= rsv_wr; // [R8]
					service_request_pending_r <= rsv_wr; // [R8]
				end
			end
			default: sp_r <= gpr_pkg::SP_IDLE;
			endcase
		end
	end

	// parallel poll as controller and individual status
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			rpp_r  <= 1'b0;
			co_r   <= 1'b0;
			command_pass_through_reg_r <= 8'h00;
			ist_r  <= 1'b0;
		end else begin
			if (wr && paddr_i == gpr_pkg::ADDR_AUXC) begin
				if (pwdata_i[7:0] == gpr_pkg::AUX_EPP) rpp_r <= 1'b1;
				if (pwdata_i[7:0] == gpr_pkg::AUX_SPP) ist_r <= 1'b1; // [R20]
				if (pwdata_i[7:0] == gpr_pkg::AUX_CPP) ist_r <= 1'b0; // [R20]
			end
			if (rpp_r && ctl_wait_i) begin
				command_pass_through_reg_r <= bus_i.dio; // [R11]
				rpp_r  <= 1'b0; // [R11]
				co_r   <= 1'b1; // [R11]
			end else if (cmd_sent_i || !ctl_active_i) begin
				command_pass_through_reg_r <= 8'h00; // [R12]
				co_r   <= 1'b0;
			end
		end
	end

	// bus drive
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			srq_r <= 1'b0;
			eoi_r <= 1'b0;
			dio_r <= 8'h00;
			oe_r  <= 8'h00;
		end else begin
			srq_r <= (sp_r == gpr_pkg::SP_ASSERT) & ~(talk_addr_i & atn_q_r & ~bus_i.atn); // [R7]
			eoi_r <= 1'b0;
			dio_r <= 8'h00;
			oe_r  <= 8'h00;
			if (rpp_r && ctl_wait_i) begin
				eoi_r <= 1'b1; // [R10]
			end else if (sp_r == gpr_pkg::SP_TALK && !bus_i.atn) begin
				dio_r <= {stb_r[7], 1'b1, stb_r[5:0]}; // [R7]
				oe_r  <= 8'hFF;
				eoi_r <= auxb_r[gpr_pkg::BIT_EOI]; // [R9]
			end else if (bus_i.idy && !ppcfg_r[gpr_pkg::BIT_UNCFG]) begin
				// one line only, open collector: drive low-true only when response true
				if (ist == ppcfg_r[gpr_pkg::BIT_SENSE]) begin // [R14]
					dio_r[ppcfg_r[2:0]] <= 1'b1; // [R13]
					oe_r[ppcfg_r[2:0]]  <= 1'b1; // [R15]
				end
			end // idy gone: drive dropped next edge [R22]
		end
	end
	assign bus_o.srq    = srq_r;
	assign bus_o.eoi    = eoi_r;
	assign bus_o.dio    = dio_r;
	assign bus_o.dio_oe = oe_r;

	property p_service_request_pending_set;
		@(posedge clk_sys_i) disable iff (!resetn_i) rsv_wr |=> service_request_pending_r;
	endproperty
	a_service_request_pending_set: assert property (p_service_request_pending_set) else $error("pending not set"); // [R5]
	property p_srq_wait;
		@(posedge clk_sys_i) disable iff (!resetn_i) spas_r |-> !srq_r;
	endproperty
	a_srq_wait: assert property (p_srq_wait) else $error("srq during poll"); // [R6]
	property p_end_clr;
		@(posedge clk_sys_i) disable iff (!resetn_i) poll_end && !rsv_wr |=> !service_request_pending_r && !rsv_r;
	endproperty
	a_end_clr: assert property (p_end_clr) else $error("poll end clear missed"); // [R8]
	property p_one_line;
		@(posedge clk_sys_i) disable iff (!resetn_i) sp_r != gpr_pkg::SP_TALK |-> $onehot0(oe_r);
	endproperty
	a_one_line: assert property (p_one_line) else $error("more than one poll line"); // [R13]
	property p_release;
		@(posedge clk_sys_i) disable iff (!resetn_i)
			!bus_i.idy && sp_r != gpr_pkg::SP_TALK |=> oe_r == 8'h00;
	endproperty
	a_release: assert property (p_release) else $error("poll drive held"); // [R22]
	property p_co;
		@(posedge clk_sys_i) disable iff (!resetn_i) rpp_r && ctl_wait_i |=> co_r && command_pass_through_reg_r == $past(bus_i.dio);
	endproperty
	a_co: assert property (p_co) else $error("capture missed"); // [R11]
	property p_line0;
		@(posedge clk_sys_i) disable iff (!resetn_i) bus_i.srq |=> !dma_status_line0_n_o;
	endproperty
	a_line0: assert property (p_line0) else $error("line0 wrong"); // [R1]
	property p_line2;
		@(posedge clk_sys_i) disable iff (!resetn_i) !sel_ren_i |=> dma_status_line2_n_o == $past(srqb_n_i);
	endproperty
	a_line2: assert property (p_line2) else $error("line2 wrong"); // [R2]
endmodule
`default_nettype wire

// ---- tb/gpr_cic_model.sv ----
// Purpose: controller-in-charge and other instruments on one bus port
// Assumes: bus levels active high inside, data lines wired-or
// Notes: the bench steers the model registers right after rising edges
`timescale 1ns/1ns
`default_nettype none
module gpr_cic_model #(
	parameter logic [7:0] UNL_CODE = 8'h3F
) (
	// clock
	input  wire logic                  clk_sys_i,
	// device side and bus levels
	input  wire gpr_pkg::gpr_bus_out_s dev_i,
	output gpr_pkg::gpr_bus_in_s       bus_o
);
	logic       atn_r = 1'h0, idy_r = 1'h0, cv_r = 1'h0, ren_r = 1'h0, srq_r = 1'h0;
	logic [7:0] cmd_r = 8'h00, inst_r = 8'h00;
	// a true level from any party wins on srq, and on the data lines except while a command byte is sent
	assign bus_o.atn       = atn_r;
	assign bus_o.idy       = idy_r;
	assign bus_o.srq       = dev_i.srq | srq_r;
	assign bus_o.ren       = ren_r;
	assign bus_o.cmd_valid = cv_r;
	assign bus_o.dio       = cv_r ? cmd_r : (dev_i.dio & dev_i.dio_oe) | inst_r;
	// one command byte under atn, atn left asserted
	task automatic send_cmd(input logic [7:0] b);
		@(posedge clk_sys_i);
		atn_r <= 1'h1;
		cmd_r <= b;
		cv_r  <= 1'h1;
		@(posedge clk_sys_i);
		cv_r  <= 1'h0;
	endtask
endmodule
`default_nettype wire

// ---- tb/gpr_poll_response_logic_tb_top.sv ----
// Purpose: self-checking bench for the poll response block
// Assumes: bus model beside the block, apb master task
// Notes: drives after rising edges, samples on falling edges
`timescale 1ns/1ns
`default_nettype none
module gpr_poll_response_logic_tb_top;
	typedef struct packed {
		logic        w;
		logic [7:0]  a;
		logic [31:0] d;
		logic        e;
	} gpr_row_s;
	logic                  clk_sys_i = 1'h0, resetn_i = 1'h0;
	logic                  psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]            paddr = 8'h00;
	logic [31:0]           pwdata = 32'h0, prdata, r;
	logic                  pready, pslverr, e, dl0, dl2;
	logic                  ctl_active = 1'h0, ctl_wait = 1'h0, talk = 1'h0, listen = 1'h0;
	logic                  srqb_n = 1'h1, sel_ren = 1'h0, cmd_sent = 1'h0;
	gpr_pkg::gpr_bus_in_s  bus_i;
	gpr_pkg::gpr_bus_out_s bus_o;
	int                    fail_count = 0, checks = 0;
	gpr_row_s              rows [6];
	always #50 clk_sys_i = ~clk_sys_i;
	gpr_poll DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ctl_active_i(ctl_active),
		.ctl_wait_i(ctl_wait), .cmd_sent_i(cmd_sent), .talk_addr_i(talk), .listen_addr_i(listen),
		.bus_i(bus_i), .bus_o(bus_o), .srqb_n_i(srqb_n), .sel_ren_i(sel_ren),
		.dma_status_line0_n_o(dl0), .dma_status_line2_n_o(dl2));
	gpr_cic_model CIC (.clk_sys_i(clk_sys_i), .dev_i(bus_o), .bus_o(bus_i));
	task automatic report_and_stop();
		if (fail_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		checks++;
		if (s !== x) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_i);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		penable <= 1'h1;
		n = 0;
		@(posedge clk_sys_i);
		while (pready !== 1'h1 && n < 50) begin
			n++;
			@(posedge clk_sys_i);
		end
		if (n == 50) begin
			fail_count++;
			report_and_stop();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		report_and_stop();
	end
	initial begin
		rows = '{'{1'h0, gpr_pkg::ADDR_PPCFG, 32'h10, 1'h0},
			'{1'h1, gpr_pkg::ADDR_PPCFG, 32'h0B, 1'h0},
			'{1'h0, gpr_pkg::ADDR_PPCFG, 32'h0B, 1'h0},
			'{1'h1, gpr_pkg::ADDR_AUXB, 32'h02, 1'h0},
			'{1'h0, gpr_pkg::ADDR_AUXB, 32'h02, 1'h0},
			'{1'h0, 8'h1C, 32'h0, 1'h1}};
		settle(3);
		chk("line0", 32'h1, 32'(dl0));
		chk("oe", 32'h0, 32'(bus_o.dio_oe));
		@(posedge clk_sys_i);
		resetn_i <= 1'h1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].w ? rows[i].d : 32'h0);
			if (!rows[i].w) chk("rdata", rows[i].d, r);
			chk("err", 32'(rows[i].e), 32'(e));
		end
		// every line and sense, ist from the aux commands
		for (int i = 0; i < 16; i++) begin
			apb(1'h1, gpr_pkg::ADDR_PPCFG, 32'(i));
			apb(1'h1, gpr_pkg::ADDR_AUXC, 32'(i[0] ? gpr_pkg::AUX_SPP : gpr_pkg::AUX_CPP));
			@(posedge clk_sys_i);
			CIC.idy_r <= 1'h1;
			settle(2);
			chk("oe", (i[0] == i[3]) ? 32'h1 << i[2:0] : 32'h0, 32'(bus_o.dio_oe));
			chk("dio", (i[0] == i[3]) ? 32'h1 << i[2:0] : 32'h0, 32'(bus_i.dio));
			@(posedge clk_sys_i);
			CIC.idy_r <= 1'h0;
			settle(2);
			chk("release", 32'h0, 32'(bus_o.dio_oe));
		end
		// service request, ist tied to it, then a serial poll
		apb(1'h1, gpr_pkg::ADDR_PPCFG, 32'h0D);
		apb(1'h1, gpr_pkg::ADDR_AUXB, 32'h06);
		apb(1'h0, 8'h04, 32'h0);
		chk("pending", 32'h0, 32'(r[6]));
		apb(1'h1, 8'h00, 32'h45);
		apb(1'h0, 8'h04, 32'h0);
		chk("pending", 32'h1, 32'(r[6]));
		for (int n = 0; n < 20 && bus_o.srq !== 1'h1; n++) @(negedge clk_sys_i);
		chk("srq", 32'h1, 32'(bus_o.srq));
		settle(1);
		chk("line0", 32'h0, 32'(dl0));
		@(posedge clk_sys_i);
		CIC.idy_r <= 1'h1;
		settle(2);
		chk("ist", 32'h20, 32'(bus_o.dio_oe));
		@(posedge clk_sys_i);
		CIC.idy_r <= 1'h0;
		talk <= 1'h1;
		CIC.atn_r <= 1'h1;
		@(posedge clk_sys_i);
		CIC.atn_r <= 1'h0;
		settle(2);
		chk("stb", 32'h45, 32'(bus_o.dio));
		chk("stb_oe", 32'hFF, 32'(bus_o.dio_oe));
		chk("srq_off", 32'h0, 32'(bus_o.srq));
		chk("eoi", 32'h1, 32'(bus_o.eoi));
		apb(1'h0, 8'h04, 32'h0);
		chk("pending", 32'h1, 32'(r[6]));
		@(posedge clk_sys_i);
		CIC.atn_r <= 1'h1;
		talk <= 1'h0;
		apb(1'h0, 8'h04, 32'h0);
		chk("pending", 32'h0, 32'(r[6]));
		chk("srq_end", 32'h0, 32'(bus_o.srq));
		// second status line from either source
		@(posedge clk_sys_i);
		sel_ren <= 1'h1;
		CIC.ren_r <= 1'h1;
		settle(2);
		chk("line2", 32'h0, 32'(dl2));
		@(posedge clk_sys_i);
		sel_ren <= 1'h0;
		settle(2);
		chk("line2", 32'h1, 32'(dl2));
		@(posedge clk_sys_i);
		srqb_n <= 1'h0;
		settle(2);
		chk("line2", 32'h0, 32'(dl2));
		// executed parallel poll as controller
		apb(1'h1, gpr_pkg::ADDR_PPCFG, 32'h10);
		@(posedge clk_sys_i);
		ctl_active <= 1'h1;
		CIC.inst_r <= 8'hA5;
		apb(1'h1, gpr_pkg::ADDR_AUXC, 32'(gpr_pkg::AUX_EPP));
		@(posedge clk_sys_i);
		ctl_wait <= 1'h1;
		settle(1);
		chk("idy_out", 32'h1, 32'(bus_o.eoi));
		@(posedge clk_sys_i);
		ctl_wait <= 1'h0;
		CIC.inst_r <= 8'h00;
		apb(1'h0, gpr_pkg::ADDR_COMMAND_PASS_THROUGH_REG, 32'h0);
		chk("capture", 32'hA5, r);
		apb(1'h0, gpr_pkg::ADDR_STAT, 32'h0);
		chk("done", 32'h1, 32'(r[0]));
		@(posedge clk_sys_i);
		cmd_sent <= 1'h1;
		@(posedge clk_sys_i);
		cmd_sent <= 1'h0;
		apb(1'h0, gpr_pkg::ADDR_STAT, 32'h0);
		chk("done_clr", 32'h0, 32'(r[0]));
		// remote configuration, then remote disable
		apb(1'h1, gpr_pkg::ADDR_AUXB, 32'h00);
		apb(1'h1, gpr_pkg::ADDR_PPCFG, 32'h20);
		apb(1'h1, gpr_pkg::ADDR_AUXC, 32'(gpr_pkg::AUX_SPP));
		CIC.send_cmd(CIC.UNL_CODE);
		listen <= 1'h1;
		CIC.send_cmd(gpr_pkg::CMD_PPC);
		CIC.send_cmd(gpr_pkg::PPE_CODE | 8'h0A);
		CIC.idy_r <= 1'h1;
		settle(2);
		chk("remote", 32'h04, 32'(bus_o.dio_oe));
		@(posedge clk_sys_i);
		CIC.idy_r <= 1'h0;
		CIC.send_cmd(gpr_pkg::CMD_PPC);
		CIC.send_cmd(gpr_pkg::PPD_CODE);
		CIC.idy_r <= 1'h1;
		settle(2);
		chk("disabled", 32'h0, 32'(bus_o.dio_oe));
		report_and_stop();
	end
endmodule
`default_nettype wire
